// >>> pkg/pss_consts.vh
// register map, field positions, reset values and timing counts of the proximity sequencer
`ifndef PSS_CONSTS_VH
`define PSS_CONSTS_VH

// register byte offsets
`define PSS_ADDR_CTRL 8'h00
`define PSS_ADDR_COMP 8'h04
`define PSS_ADDR_STAT 8'h08
`define PSS_ADDR_RAW 8'h0C
`define PSS_ADDR_THR 8'h10

// control register fields
`define PSS_PERIOD_LSB 0
`define PSS_PERIOD_MSB 7
`define PSS_SENSOR_BIT 8
`define PSS_SHIELD_BIT 9
`define PSS_GAIN_LSB 10
`define PSS_GAIN_MSB 12
`define PSS_BOOST_BIT 13
`define PSS_FREQ_LSB 14
`define PSS_FREQ_MSB 15
`define PSS_IMMUN_BIT 16
`define PSS_CTRL_MSB 16

// compensation request and status fields
`define PSS_COMP_REQ_BIT 0
`define PSS_STAT_NEAR_BIT 0
`define PSS_STAT_PEND_BIT 1
`define PSS_STAT_BUSY_BIT 2

// reset values
`define PSS_CTRL_RST 17'h00000
`define PSS_THR_RST 12'h800

// code width of the shared converter
`define PSS_RAW_W 12

// timing: one scan period unit
`define PSS_CLK_MHZ 100
`define PSS_SCAN_UNIT_US 1000
`define PSS_SCAN_UNIT_CYC (`PSS_SCAN_UNIT_US * `PSS_CLK_MHZ)

`endif

// >>> rtl/pss_adc_arbiter.v
// converter ownership arbiter between touch and proximity users
`timescale 1ns/1ns
module pss_adc_arbiter (
  // clock and reset
  input wire sys_clk,
  input wire rstn,
  // requests
  input wire touch_req,
  input wire prox_req,
  // grants
  output reg touch_gnt,
  output reg prox_gnt
);
  // a grant is held until its owner drops the request; touch wins a tie
  always @(posedge sys_clk) begin
    if (!rstn) begin
      touch_gnt <= 1'b0;
      prox_gnt <= 1'b0;
    end else if (touch_gnt) begin
      touch_gnt <= touch_req;
    end else if (prox_gnt) begin
      prox_gnt <= prox_req;
    end else if (touch_req) begin
      touch_gnt <= 1'b1;
    end else if (prox_req) begin
      prox_gnt <= 1'b1;
    end
  end
endmodule // pss_adc_arbiter

// >>> rtl/pss_scan_timer.v
// scan period timer producing one wake pulse per programmed period
`timescale 1ns/1ns
module pss_scan_timer #(
  parameter UNIT_CYCLES = 100000,
  parameter CNT_W = 20,
  parameter PER_W = 8
) (
  // clock and reset
  input wire sys_clk,
  input wire rstn,
  // control
  input wire [PER_W-1:0] period,
  input wire restart,
  // event
  output reg wake
);
  localparam [31:0] UNIT_LAST_W = UNIT_CYCLES - 1;
  localparam [CNT_W-1:0] UNIT_LAST = UNIT_LAST_W[CNT_W-1:0];
  localparam [PER_W-1:0] PER_ONE = {{(PER_W-1){1'b0}}, 1'b1};

  reg [CNT_W-1:0] unit_reg;
  reg [PER_W-1:0] per_reg;
  wire unit_tick;

  assign unit_tick = (unit_reg == UNIT_LAST);

  always @(posedge sys_clk) begin
    if (!rstn || restart || period == {PER_W{1'b0}}) begin
      unit_reg <= {CNT_W{1'b0}};
      per_reg <= {PER_W{1'b0}};
      wake <= 1'b0;
    end else begin
      wake <= 1'b0;
      if (unit_tick) begin
        unit_reg <= {CNT_W{1'b0}};
        if (per_reg == period - PER_ONE) begin
          per_reg <= {PER_W{1'b0}};
          wake <= 1'b1;
        end else begin
          per_reg <= per_reg + PER_ONE;
        end
      end else begin
        unit_reg <= unit_reg + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule // pss_scan_timer

// >>> rtl/pss_sequencer.v
// proximity sense sequencer top: register slave, scan sequencing, compensation control
//
// Decided for this implementation: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ns
`include "pss_consts.vh"

// What this block does
// - idle between scans; wake once per scan period for one sample.
// - sensor select drives top layer or second auxiliary pin as electrode.
// - shield select drives bottom layer or third auxiliary pin as shield.
// - each acquisition stores a 12-bit unsigned raw capacitance code.
// - processing reduces the raw code to one near/far flag.
// - the sequencer itself issues compensation and measurement start requests.
// - converter is shared with touch; only one user holds it.
// - compensation measures environment once, subtracted until next compensation.
// - five request sources each set the pending-compensation flag.
// - pending flag clears only after compensation fully completes.
// - frequency field sets the sensing frequency; host keeps it high.
// - high-immunity option runs the front-end in noise immune mode.
// - zero scan period starts no new scan; one already under way runs to its end.
// - writing a nonzero scan period from zero requests compensation.
// - host may request compensation any time over the register bus.
// - pending compensation runs at scan start, before the raw measurement.
module pss_sequencer #(
  parameter SCAN_UNIT_CYCLES = `PSS_SCAN_UNIT_CYC
) (
  // clock and reset
  input wire sys_clk,
  input wire rstn,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire hready,
  input wire [31:0] hwdata,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  // compensation requests from the processing stage
  input wire drift_comp_req,
  input wire periodic_comp_req,
  input wire stuck_comp_req,
  // converter sharing with touch
  input wire touch_adc_req,
  output wire touch_adc_gnt,
  // analog front-end and converter
  output wire afe_comp_start,
  input wire afe_comp_done,
  output wire afe_conv_start,
  input wire adc_done,
  input wire [`PSS_RAW_W-1:0] adc_data,
  // electrode routing and front-end settings
  output reg sense_top_en,
  output reg sense_second_auxiliary_pin_en,
  output reg shield_bottom_en,
  output reg shield_third_auxiliary_pin_en,
  output reg [2:0] afe_gain,
  output reg afe_boost,
  output reg [1:0] afe_freq,
  output reg afe_high_immunity,
  // status
  output wire near_far_flag,
  output wire compensation_pending_flag,
  output wire prox_busy,
  output wire [`PSS_RAW_W-1:0] raw_capacitance_code
);
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ARB = 3'h1;
  localparam [2:0] ST_COMP = 3'h2;
  localparam [2:0] ST_COMPW = 3'h3;
  localparam [2:0] ST_CONV = 3'h4;
  localparam [2:0] ST_CONVW = 3'h5;
  localparam [2:0] ST_PROC = 3'h6;

  // bus address phase capture
  reg dph_wr_reg;
  reg [7:0] dph_addr_reg;
  wire aph_valid;
  wire [7:0] aph_addr;

  // registers
  reg [`PSS_CTRL_MSB:0] ctrl_reg;
  reg [`PSS_RAW_W-1:0] thr_reg;
  reg [`PSS_RAW_W-1:0] raw_reg;
  reg near_reg;
  reg pend_reg;
  reg pend_next;
  reg late_req_reg;
  reg wake_pend_reg;
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [31:0] rd_mux;

  wire [7:0] period;
  wire ctrl_wr;
  wire host_comp;
  wire startup_comp;
  wire comp_set;
  wire comp_clr;
  wire wake;
  wire prox_gnt;
  wire prox_req;
  wire active_next;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign aph_valid = hsel & htrans[1] & hready;
  assign aph_addr = {haddr[7:2], 2'b00};

  assign period = ctrl_reg[`PSS_PERIOD_MSB:`PSS_PERIOD_LSB];
  assign ctrl_wr = dph_wr_reg & (dph_addr_reg == `PSS_ADDR_CTRL);
  assign host_comp = dph_wr_reg & (dph_addr_reg == `PSS_ADDR_COMP) &
                     hwdata[`PSS_COMP_REQ_BIT];
  assign startup_comp = ctrl_wr & (period == 8'h00) &
                        (hwdata[`PSS_PERIOD_MSB:`PSS_PERIOD_LSB] != 8'h00);
  assign comp_set = host_comp | startup_comp | drift_comp_req |
                    periodic_comp_req | stuck_comp_req;
  assign comp_clr = (state_reg == ST_COMPW) & afe_comp_done & ~late_req_reg;

  assign afe_comp_start = (state_reg == ST_COMP);
  assign afe_conv_start = (state_reg == ST_CONV);
  assign prox_req = (state_reg != ST_IDLE);
  assign prox_busy = prox_req;
  assign near_far_flag = near_reg;
  assign compensation_pending_flag = pend_reg;
  assign raw_capacitance_code = raw_reg;

  pss_scan_timer #(
    .UNIT_CYCLES(SCAN_UNIT_CYCLES),
    .CNT_W(20),
    .PER_W(8)
  ) u_timer (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .period(period),
    .restart(ctrl_wr),
    .wake(wake)
  );

  pss_adc_arbiter u_arb (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .touch_req(touch_adc_req),
    .prox_req(prox_req),
    .touch_gnt(touch_adc_gnt),
    .prox_gnt(prox_gnt)
  );

  // bus: capture address phase, write in data phase
  always @(posedge sys_clk) begin
    if (!rstn) begin
      dph_wr_reg <= 1'b0;
      dph_addr_reg <= 8'h00;
    end else if (hready) begin
      dph_wr_reg <= aph_valid & hwrite;
      dph_addr_reg <= aph_addr;
    end
  end

  always @(posedge sys_clk) begin
    if (!rstn) begin
      ctrl_reg <= `PSS_CTRL_RST;
      thr_reg <= `PSS_THR_RST;
    end else if (dph_wr_reg) begin
      if (dph_addr_reg == `PSS_ADDR_CTRL) begin
        ctrl_reg <= hwdata[`PSS_CTRL_MSB:0];
      end else if (dph_addr_reg == `PSS_ADDR_THR) begin
        thr_reg <= hwdata[`PSS_RAW_W-1:0];
      end
    end
  end

  // read data is registered at the address phase, so a read right after
  // a write to the same register still returns the old value
  always @* begin
    rd_mux = 32'h00000000;
    if (aph_addr == `PSS_ADDR_CTRL) begin
      rd_mux[`PSS_CTRL_MSB:0] = ctrl_reg;
    end else if (aph_addr == `PSS_ADDR_STAT) begin
      rd_mux[`PSS_STAT_NEAR_BIT] = near_reg;
      rd_mux[`PSS_STAT_PEND_BIT] = pend_reg;
      rd_mux[`PSS_STAT_BUSY_BIT] = prox_busy;
    end else if (aph_addr == `PSS_ADDR_RAW) begin
      rd_mux[`PSS_RAW_W-1:0] = raw_reg;
    end else if (aph_addr == `PSS_ADDR_THR) begin
      rd_mux[`PSS_RAW_W-1:0] = thr_reg;
    end
  end

  always @(posedge sys_clk) begin
    if (!rstn) begin
      hrdata <= 32'h00000000;
    end else if (aph_valid & ~hwrite) begin
      hrdata <= rd_mux;
    end
  end

  // a request landing while a compensation runs was not served by it,
  // so the flag must survive that compensation and wait for the next scan
  always @(posedge sys_clk) begin
    if (!rstn) begin
      late_req_reg <= 1'b0;
    end else if (state_reg == ST_COMP || state_reg == ST_COMPW) begin
      late_req_reg <= late_req_reg | comp_set;
    end else begin
      late_req_reg <= 1'b0;
    end
  end

  // pending compensation: a new request in the clearing cycle wins
  always @* begin
    pend_next = pend_reg;
    if (comp_set) begin
      pend_next = 1'b1;
    end else if (comp_clr) begin
      pend_next = 1'b0;
    end
  end

  // wake request survives until the sequencer leaves idle
  always @(posedge sys_clk) begin
    if (!rstn || period == 8'h00) begin
      wake_pend_reg <= 1'b0;
    end else if (wake) begin
      wake_pend_reg <= 1'b1;
    end else if (state_reg == ST_IDLE && state_next == ST_ARB) begin
      wake_pend_reg <= 1'b0;
    end
  end

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (wake_pend_reg && period != 8'h00) begin
          state_next = ST_ARB;
        end
      end
      ST_ARB: begin
        if (prox_gnt) begin
          if (pend_reg) begin
            state_next = ST_COMP;
          end else begin
            state_next = ST_CONV;
          end
        end
      end
      ST_COMP: begin
        state_next = ST_COMPW;
      end
      ST_COMPW: begin
        if (afe_comp_done) begin
          state_next = ST_CONV;
        end
      end
      ST_CONV: begin
        state_next = ST_CONVW;
      end
      ST_CONVW: begin
        if (adc_done) begin
          state_next = ST_PROC;
        end
      end
      ST_PROC: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always @(posedge sys_clk) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;
      pend_reg <= 1'b0;
      raw_reg <= {`PSS_RAW_W{1'b0}};
      near_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      pend_reg <= pend_next;
      if (state_reg == ST_CONVW && adc_done) begin
        raw_reg <= adc_data;
      end
      if (state_reg == ST_PROC) begin
        near_reg <= (raw_reg > thr_reg);
      end
    end
  end

  // electrodes are routed whenever the sequencer is out of idle, including while it waits in ST_ARB for the grant
  assign active_next = (state_next != ST_IDLE);

  always @(posedge sys_clk) begin
    if (!rstn) begin
      sense_top_en <= 1'b0;
      sense_second_auxiliary_pin_en <= 1'b0;
      shield_bottom_en <= 1'b0;
      shield_third_auxiliary_pin_en <= 1'b0;
      afe_gain <= 3'h0;
      afe_boost <= 1'b0;
      afe_freq <= 2'h0;
      afe_high_immunity <= 1'b0;
    end else begin
      sense_top_en <= active_next & ~ctrl_reg[`PSS_SENSOR_BIT];
      sense_second_auxiliary_pin_en <= active_next & ctrl_reg[`PSS_SENSOR_BIT];
      shield_bottom_en <= active_next & ~ctrl_reg[`PSS_SHIELD_BIT];
      shield_third_auxiliary_pin_en <= active_next & ctrl_reg[`PSS_SHIELD_BIT];
      afe_gain <= ctrl_reg[`PSS_GAIN_MSB:`PSS_GAIN_LSB];
      // boost has no effect with the touchscreen layer as sensor
      afe_boost <= ctrl_reg[`PSS_BOOST_BIT] & ctrl_reg[`PSS_SENSOR_BIT];
      afe_freq <= ctrl_reg[`PSS_FREQ_MSB:`PSS_FREQ_LSB];
      afe_high_immunity <= ctrl_reg[`PSS_IMMUN_BIT];
    end
  end
endmodule // pss_sequencer

// >>> test/pss_afe_model.sv
// behavioural front-end and converter answering the sequencer
`timescale 1ns/1ns
module pss_afe_model (
  // clock and starts
  input wire sys_clk,
  input wire comp_start,
  input wire conv_start,
  // answer delay and code
  input wire [7:0] dly,
  input wire [11:0] code,
  // answers
  output logic comp_done,
  output logic conv_done,
  output logic [11:0] data
);
  initial begin
    comp_done = 1'b0;
    forever begin
      do @(posedge sys_clk); while (comp_start !== 1'b1);
      repeat (dly) @(posedge sys_clk);
      comp_done <= 1'b1;
      @(posedge sys_clk);
      comp_done <= 1'b0;
    end
  end
  initial begin
    conv_done = 1'b0;
    data = 12'h0;
    forever begin
      do @(posedge sys_clk); while (conv_start !== 1'b1);
      repeat (dly) @(posedge sys_clk);
      conv_done <= 1'b1;
      data <= code;
      @(posedge sys_clk);
      conv_done <= 1'b0;
      // data is only valid in the done cycle
      data <= ~code;
    end
  end
endmodule // pss_afe_model

// >>> test/pss_seq_properties.sv
// checker for the proximity sequencer ports
`timescale 1ns/1ns
module pss_seq_props (
  // clock and reset
  input wire sys_clk,
  input wire rstn,
  // requests and grant
  input wire drift_comp_req,
  input wire touch_adc_gnt,
  // front-end handshake
  input wire afe_comp_start,
  input wire afe_comp_done,
  input wire afe_conv_start,
  input wire adc_done,
  input wire [11:0] adc_data,
  // electrodes
  input wire sense_top_en,
  input wire sense_second_auxiliary_pin_en,
  input wire shield_bottom_en,
  input wire shield_third_auxiliary_pin_en,
  // status
  input wire near_far_flag,
  input wire compensation_pending_flag,
  input wire prox_busy,
  input wire [11:0] raw_capacitance_code
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // electrodes are registered from the next state, so they switch on the same edge as busy
  wire elec_on = sense_top_en | sense_second_auxiliary_pin_en | shield_bottom_en | shield_third_auxiliary_pin_en;
  a_idle_no_start: assert property (!prox_busy |-> !afe_comp_start && !afe_conv_start)
    else $error("front-end started while idle");
  a_raw_from_adc: assert property (adc_done && prox_busy |=>
    raw_capacitance_code == $past(adc_data)) else $error("raw code not captured");
  a_hold_idle: assert property (!prox_busy && !$past(prox_busy) |->
    $stable(raw_capacitance_code) && $stable(near_far_flag)) else $error("status moved");
  a_pend_held: assert property (compensation_pending_flag && !afe_comp_done |=>
    compensation_pending_flag) else $error("pending cleared early");
  a_req_sets: assert property (drift_comp_req |=> compensation_pending_flag)
    else $error("request lost");
  a_comp_pend: assert property (afe_comp_start |-> compensation_pending_flag)
    else $error("compensation without request");
  a_touch_excl: assert property (touch_adc_gnt |-> !afe_conv_start && !afe_comp_start)
    else $error("converter shared");
  a_elec_busy: assert property (elec_on |-> prox_busy || $past(prox_busy))
    else $error("electrode driven while idle");
  a_one_pin: assert property (!(sense_top_en && sense_second_auxiliary_pin_en) &&
    !(shield_bottom_en && shield_third_auxiliary_pin_en)) else $error("two pins selected");
  a_conv_pulse: assert property (afe_conv_start |=> !afe_conv_start)
    else $error("start not a pulse");
  c_comp: cover property (afe_comp_start);
  c_conv: cover property (adc_done && !compensation_pending_flag);
  c_touch_wait: cover property (touch_adc_gnt && prox_busy);
endmodule // pss_seq_props

bind pss_sequencer pss_seq_props pss_seq_props_inst (.sys_clk(sys_clk), .rstn(rstn),
  .drift_comp_req(drift_comp_req), .touch_adc_gnt(touch_adc_gnt),
  .afe_comp_start(afe_comp_start), .afe_comp_done(afe_comp_done),
  .afe_conv_start(afe_conv_start), .adc_done(adc_done), .adc_data(adc_data),
  .sense_top_en(sense_top_en), .sense_second_auxiliary_pin_en(sense_second_auxiliary_pin_en),
  .shield_bottom_en(shield_bottom_en), .shield_third_auxiliary_pin_en(shield_third_auxiliary_pin_en),
  .near_far_flag(near_far_flag), .compensation_pending_flag(compensation_pending_flag),
  .prox_busy(prox_busy), .raw_capacitance_code(raw_capacitance_code));

// >>> test/testbench.sv
// self-checking bench for the proximity sequencer
`timescale 1ns/1ns
module testbench;
  logic sys_clk, rstn, hsel, hwrite, touch_req;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, q;
  logic [2:0] reqs;
  logic [11:0] code;
  logic [7:0] dly;
  int comps = 0, convs = 0, checked = 0, miscompares = 0;
  wire hready, hresp, touch_gnt, cst, cdn, vst, vdn, near, pend, busy, boost, imm;
  wire [31:0] hrdata;
  wire [11:0] adata, raw;
  wire [3:0] elec;
  wire [2:0] gain;
  wire [1:0] freq;
  pss_sequencer #(.SCAN_UNIT_CYCLES(10)) pss_sequencer_inst (.sys_clk(sys_clk), .rstn(rstn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
    .hready(hready), .hwdata(hwdata), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
    .drift_comp_req(reqs[0]), .periodic_comp_req(reqs[1]), .stuck_comp_req(reqs[2]),
    .touch_adc_req(touch_req), .touch_adc_gnt(touch_gnt), .afe_comp_start(cst),
    .afe_comp_done(cdn), .afe_conv_start(vst), .adc_done(vdn), .adc_data(adata),
    .sense_top_en(elec[3]), .sense_second_auxiliary_pin_en(elec[2]), .shield_bottom_en(elec[1]),
    .shield_third_auxiliary_pin_en(elec[0]), .afe_gain(gain), .afe_boost(boost), .afe_freq(freq),
    .afe_high_immunity(imm), .near_far_flag(near), .compensation_pending_flag(pend),
    .prox_busy(busy), .raw_capacitance_code(raw));
  pss_afe_model pss_afe_model_inst (.sys_clk(sys_clk), .comp_start(cst), .conv_start(vst),
    .dly(dly), .code(code), .comp_done(cdn), .conv_done(vdn), .data(adata));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // counted mid-cycle so that tasks waking on the rising edge never race the count
  always @(negedge sys_clk) begin
    if (cst === 1'b1) comps++;
    if (vst === 1'b1) convs++;
  end
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task test_done;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge sys_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge sys_clk); while (hready !== 1'b1);
    q = hrdata;
    chk("hresp", hresp, 0);
  endtask
  task wait_busy;
    int n;
    n = 0;
    while (busy !== 1'b1 && n < 100) begin
      @(posedge sys_clk);
      n++;
    end
    repeat (2) @(posedge sys_clk);
  endtask
  task wait_idle(input int c, input int k);
    int n;
    n = 0;
    while ((convs != c || busy !== 1'b0) && n < 300) begin
      @(posedge sys_clk);
      n++;
    end
    chk("convs", convs, c);
    chk("comps", comps, k);
  endtask
  task t_reset;
    chk("idle", {near, pend, busy, raw}, 0);
    bus(0, 8'h10, 0);
    chk("thr", q, 32'h800);
    bus(0, 8'h3C, 0);
    chk("unmapped", q, 0);
    repeat (50) @(posedge sys_clk);
    chk("off", convs, 0);
  endtask
  task t_start;
    dly = 8'h06;
    code = 12'h9A5;
    bus(1, 8'h00, 32'h1B704);
    bus(0, 8'h00, 0);
    chk("ctrl", q, 32'h1B704);
    @(posedge sys_clk);
    chk("pend_start", pend, 1);
    wait_busy;
    chk("elec_ext", elec, 4'b0101);
    chk("afe", {imm, freq, boost, gain}, 7'h6D);
    wait_idle(1, 1);
    bus(0, 8'h08, 0);
    chk("stat", q, 1);
    bus(0, 8'h0C, 0);
    chk("raw", q, 32'h9A5);
    dly = 8'h01;
    code = 12'h123;
    // boost requested with the touch layer as sensor must stay off
    bus(1, 8'h00, 32'h2004);
    wait_busy;
    chk("elec_top", elec, 4'b1010);
    chk("afe_off", {imm, freq, boost, gain}, 0);
    wait_idle(2, 1);
    chk("near_raw", {near, raw}, 13'h123);
  endtask
  task t_sources;
    int i;
    for (i = 0; i < 4; i++) begin
      if (i < 3) begin
        reqs <= 3'b001 << i;
        @(posedge sys_clk);
        reqs <= 3'b000;
      end else begin
        bus(1, 8'h04, 1);
      end
      repeat (2) @(posedge sys_clk);
      chk("pend_src", pend, 1);
      wait_idle(convs + 1, comps + 1);
      chk("pend_clr", pend, 0);
    end
  endtask
  task t_touch;
    int c;
    c = convs;
    touch_req <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk("touch_gnt", touch_gnt, 1);
    repeat (80) @(posedge sys_clk);
    chk("held_off", {convs == c, busy}, 2'b11);
    touch_req <= 1'b0;
    wait_idle(c + 1, comps);
  endtask
  task t_off;
    int c;
    int n;
    bus(1, 8'h00, 0);
    // a scan already under way runs to its end; none may follow it
    n = 0;
    while (busy !== 1'b0 && n < 100) begin
      @(posedge sys_clk);
      n++;
    end
    c = convs;
    reqs <= 3'b001;
    @(posedge sys_clk);
    reqs <= 3'b000;
    repeat (100) @(posedge sys_clk);
    chk("off", {convs == c, busy, pend}, 3'b101);
  endtask
  initial begin
    {rstn, hsel, hwrite, touch_req} = 4'h0;
    htrans = 2'b00;
    haddr = 32'h0;
    hwdata = 32'h0;
    reqs = 3'b000;
    code = 12'h0;
    dly = 8'h01;
    repeat (20) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    t_reset;
    t_start;
    t_sources;
    t_touch;
    t_off;
    test_done;
  end
  initial begin
    repeat (5000) @(posedge sys_clk);
    miscompares++;
    test_done;
  end
endmodule // testbench
